// ===== tmc_pkg.sv
// constants and types shared by the timer/counter block
package tmc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int PS_W = 3;
   // register offsets
   localparam logic [ADDR_W-1:0] OFF_TIMER = 8'h01;
   localparam logic [ADDR_W-1:0] OFF_INTCTL = 8'h0b;
   localparam logic [ADDR_W-1:0] OFF_INTCTL_HI = 8'h8b;
   localparam logic [ADDR_W-1:0] OFF_OPTION = 8'h81;
   // option field positions
   localparam int OPT_CS_BIT = 5;
   localparam int OPT_SE_BIT = 4;
   localparam int OPT_ASSIGN_BIT = 3;
   localparam int OPT_PS_LSB = 0;
   // interrupt_control field positions
   localparam int INT_EN_BIT = 5;
   localparam int INT_FLAG_BIT = 2;
   // reset values
   localparam logic [DATA_W-1:0] OPTION_RST = 8'hff;
   localparam logic [DATA_W-1:0] TIMER_RST = 8'h00;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [DATA_W-1:0] MAX_COUNT = 8'hff;
   localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
   localparam logic [DATA_W-1:0] ALL_ONES = 8'hff;
   // timing: clock period and instruction cycle
   localparam int CLK_NS = 100;
   localparam int TCY_NS = 400;
   localparam int CLKS_PER_TCY = TCY_NS / CLK_NS;
   localparam logic [1:0] INHIBIT_TCY = 2'h2;
   localparam logic [3:0] MASK_TOP = 4'h8;
   localparam logic [3:0] MASK_TOP_TMR = 4'h7;
   // internal phase clocks, gray order q1-q2-q3-q4
   typedef enum logic [1:0] {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b11,
      PH_Q4 = 2'b10
   } tmc_phase_type;
endpackage

// ===== tmc_pin_sync.sv
// three-flop synchroniser with agreement filter for the count pin
module tmc_pin_sync
   import tmc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic pin,
   output logic level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } tmc_sync_type;

   tmc_sync_type s_r;
   tmc_sync_type s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.s1 = pin;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      // accept a change once the second and third stages agree
      if (s_r.s2 == s_r.s3) begin
         s_nxt.lvl = s_r.s3;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign level = s_r.lvl;
endmodule

// ===== tmc_timer.sv
// 8-bit timer/counter with shared prescaler/postscaler and register port
//
// Overview of operation
// RULE1: timer mode without prescaler: count advances once per instruction cycle.
// RULE2: writing timer_count blocks incrementing for the following two instruction cycles.
// RULE3: counter mode: count advances on external_count_input edges.
// RULE4: source_edge_select clear counts rising edges, set counts falling edges.
// RULE5: prescaler_assign clear gives prescaler to timer, set gives it to watchdog.
// RULE6: timer prescale ratios run from 1:2 to 1:256 in powers of two.
// RULE7: prescaler counter has no software read or write path.
// RULE8: rollover from maximum to zero sets overflow_flag.
// RULE9: overflow_irq_enable gates the overflow interrupt request.
// RULE10: software clears overflow_flag itself; hardware never clears it.
// RULE11: no counting during sleep.
// RULE12: pin or prescaler output sampled at q2 and q4 phases.
// RULE13: without prescaler the pin stays high and low two oscillator periods each.
// RULE14: with prescaler the pin period is at least four oscillator periods over ratio.
// RULE15: counter mode increments only after the synchronisation stage.
// RULE16: timer_count write clears prescaler while assigned to timer.
// RULE17: watchdog_clear_instr clears watchdog and prescaler while assigned to watchdog.
// RULE18: one shared 8-bit prescaler, predivider or watchdog postscaler.
// RULE19: prescaler_assign may change at any time.
// RULE20: moving prescaler to watchdog needs a safe software sequence.
// RULE21: safe sequence: clear count and prescaler, clear watchdog, write assignment.
// RULE22: count keeps running after rollover; flag setting leaves count alone.
// RULE23: prescale_rate n gives a ratio of two to the power n plus one.
module tmc_timer
   import tmc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   input wire logic sleep,
   input wire logic external_count_input,
   input wire logic watchdog_clear_instr,
   input wire logic wdog_base_tick,
   output logic wdog_clear,
   output logic wdog_timeout,
   output logic overflow_irq
);
   typedef struct packed {
      tmc_phase_type phase;
      logic [DATA_W-1:0] timer_count;
      logic [DATA_W-1:0] option;
      logic flag;
      logic irq_en;
      logic [DATA_W-1:0] presc;
      logic [1:0] inhibit;
      logic pin_prev;
      logic edge_pend;
      logic [DATA_W-1:0] rdata;
      logic irq;
      logic wdog_clear;
      logic wdog_timeout;
   } tmc_state_type;

   tmc_state_type s_r;
   tmc_state_type s_nxt;
   logic pin_lvl;
   logic q4;
   logic sample;
   logic edge_now;
   logic run;
   logic tick;
   logic inc_now;
   logic cs;
   logic se;
   logic on_wdog;
   logic [PS_W-1:0] ps;
   logic wr_timer;

   // low-bit mask of the prescaler that must be all ones for an output tick
   function automatic logic [DATA_W-1:0] rate_mask(input logic [PS_W-1:0] rate, input logic to_wdog);
      logic [3:0] sh;
      sh = to_wdog ? (MASK_TOP - {1'b0, rate}) : (MASK_TOP_TMR - {1'b0, rate});
      return ALL_ONES >> sh;
   endfunction

   tmc_pin_sync u_sync (
      .clk(clk),
      .rstn(rstn),
      .pin(external_count_input),
      .level(pin_lvl)
   );

   assign cs = s_r.option[OPT_CS_BIT];
   assign se = s_r.option[OPT_SE_BIT];
   assign on_wdog = s_r.option[OPT_ASSIGN_BIT];
   assign ps = s_r.option[OPT_PS_LSB +: PS_W];
   assign q4 = (s_r.phase == PH_Q4);
   assign sample = (s_r.phase == PH_Q2) || (s_r.phase == PH_Q4); // RULE12
   assign edge_now = sample && (pin_lvl != s_r.pin_prev) && (pin_lvl == ~se); // RULE4
   assign run = q4 && !sleep && (cs ? s_r.edge_pend : 1'b1); // RULE1 RULE3 RULE11 RULE15
   assign tick = on_wdog ? run : (run && ((s_r.presc & rate_mask(ps, 1'b0)) == rate_mask(ps, 1'b0))); // RULE5 RULE6 RULE23
   assign inc_now = tick && (s_r.inhibit == 2'h0); // RULE2
   assign wr_timer = wr && (addr == OFF_TIMER);

   always_comb begin
      s_nxt = s_r;
      unique case (s_r.phase)
         PH_Q1: begin
            s_nxt.phase = PH_Q2;
         end
         PH_Q2: begin
            s_nxt.phase = PH_Q3;
         end
         PH_Q3: begin
            s_nxt.phase = PH_Q4;
         end
         PH_Q4: begin
            s_nxt.phase = PH_Q1;
         end
      endcase
      // edge capture, consumed at q4
      if (q4) begin
         s_nxt.edge_pend = 1'b0;
      end
      if (sample) begin
         s_nxt.pin_prev = pin_lvl; // RULE12
      end
      if (edge_now) begin
         s_nxt.edge_pend = 1'b1; // RULE3
      end
      // write inhibit runs down once per instruction cycle
      if (q4 && (s_r.inhibit != 2'h0)) begin
         s_nxt.inhibit = s_r.inhibit - 2'h1; // RULE2
      end
      // shared prescaler
      if (!on_wdog && run) begin
         s_nxt.presc = s_r.presc + ONE_BYTE; // RULE18
      end
      if (on_wdog && wdog_base_tick) begin
         s_nxt.presc = s_r.presc + ONE_BYTE; // RULE5 RULE18
      end
      s_nxt.wdog_timeout = wdog_base_tick;
      if (on_wdog) begin
         s_nxt.wdog_timeout = wdog_base_tick && ((s_r.presc & rate_mask(ps, 1'b1)) == rate_mask(ps, 1'b1));
      end
      if (inc_now) begin
         s_nxt.timer_count = s_r.timer_count + ONE_BYTE; // RULE22
      end
      // software writes
      if (wr_timer) begin
         s_nxt.timer_count = wdata;
         s_nxt.inhibit = INHIBIT_TCY; // RULE2
         if (!on_wdog) begin
            s_nxt.presc = ZERO_BYTE; // RULE16
         end
      end
      s_nxt.wdog_clear = watchdog_clear_instr;
      if (watchdog_clear_instr && on_wdog) begin
         s_nxt.presc = ZERO_BYTE; // RULE17
      end
      if (wr && (addr == OFF_OPTION)) begin
         s_nxt.option = wdata; // RULE19
      end
      if (wr && ((addr == OFF_INTCTL) || (addr == OFF_INTCTL_HI))) begin
         s_nxt.irq_en = wdata[INT_EN_BIT];
         s_nxt.flag = wdata[INT_FLAG_BIT];
      end
      // hardware set beats a software clear in the same cycle
      if (inc_now && (s_r.timer_count == MAX_COUNT) && !wr_timer) begin
         s_nxt.flag = 1'b1; // RULE8
      end
      s_nxt.irq = s_r.flag && s_r.irq_en; // RULE9
      // read data stand for one cycle only; prescaler is not visible
      s_nxt.rdata = ZERO_BYTE;
      if (rd) begin
         unique case (addr)
            OFF_TIMER: begin
               s_nxt.rdata = s_r.timer_count;
            end
            OFF_OPTION: begin
               s_nxt.rdata = s_r.option;
            end
            OFF_INTCTL, OFF_INTCTL_HI: begin
               s_nxt.rdata[INT_EN_BIT] = s_r.irq_en;
               s_nxt.rdata[INT_FLAG_BIT] = s_r.flag;
            end
            default: begin
               s_nxt.rdata = ZERO_BYTE; // RULE7
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r.phase <= PH_Q1;
         s_r.timer_count <= TIMER_RST;
         s_r.option <= OPTION_RST;
         s_r.flag <= 1'b0;
         s_r.irq_en <= 1'b0;
         s_r.presc <= ZERO_BYTE;
         s_r.inhibit <= 2'h0;
         s_r.pin_prev <= 1'b0;
         s_r.edge_pend <= 1'b0;
         s_r.rdata <= ZERO_BYTE;
         s_r.irq <= 1'b0;
         s_r.wdog_clear <= 1'b0;
         s_r.wdog_timeout <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata = s_r.rdata;
   assign overflow_irq = s_r.irq;
   assign wdog_clear = s_r.wdog_clear;
   assign wdog_timeout = s_r.wdog_timeout;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   sequence s_tmr_write;
      wr && (addr == OFF_TIMER);
   endsequence

   sequence s_quiet_bus;
      (!wr)[*8];
   endsequence

   property p_timer_inc;
      (q4 && !cs && on_wdog && !sleep && (s_r.inhibit == 2'h0) && !wr) |=>
         (s_r.timer_count == $past(s_r.timer_count) + ONE_BYTE);
   endproperty
   a_timer_inc: assert property (p_timer_inc) else $error("timer mode missed an increment"); // RULE1

   property p_write_inhibit;
      s_tmr_write ##1 s_quiet_bus |-> (s_r.timer_count == $past(wdata, 8));
   endproperty
   a_write_inhibit: assert property (p_write_inhibit) else $error("count moved inside write inhibit"); // RULE2

   property p_edge_count;
      (q4 && cs && on_wdog && !sleep && (s_r.inhibit == 2'h0) && !wr && s_r.edge_pend) |=>
         (s_r.timer_count == $past(s_r.timer_count) + ONE_BYTE);
   endproperty
   a_edge_count: assert property (p_edge_count) else $error("captured edge not counted"); // RULE3

   property p_edge_polarity;
      (sample && (pin_lvl != s_r.pin_prev) && (pin_lvl == se)) |=> !s_r.edge_pend || $past(s_r.edge_pend && !q4);
   endproperty
   a_edge_polarity: assert property (p_edge_polarity) else $error("wrong edge captured"); // RULE4

   property p_sample_phase;
      (s_r.pin_prev != $past(s_r.pin_prev)) |-> $past(sample);
   endproperty
   a_sample_phase: assert property (p_sample_phase) else $error("pin sampled outside q2 and q4"); // RULE12

   property p_overflow;
      (inc_now && (s_r.timer_count == MAX_COUNT) && !wr) |=> (s_r.flag && (s_r.timer_count == ZERO_BYTE));
   endproperty
   a_overflow: assert property (p_overflow) else $error("rollover did not set the flag"); // RULE8

   property p_irq_gate;
      s_r.irq |-> ($past(s_r.irq_en) && $past(s_r.flag));
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt raised while masked"); // RULE9

   property p_sleep_stop;
      (sleep && !wr) |=> (s_r.timer_count == $past(s_r.timer_count));
   endproperty
   a_sleep_stop: assert property (p_sleep_stop) else $error("count moved during sleep"); // RULE11

   property p_write_clear_presc;
      (s_tmr_write and (!on_wdog)) |=> (s_r.presc == ZERO_BYTE) && (s_r.inhibit == INHIBIT_TCY);
   endproperty
   a_write_clear_presc: assert property (p_write_clear_presc) else $error("write left prescaler set"); // RULE16

   property p_wdog_clear_presc;
      (watchdog_clear_instr && on_wdog) |=> (s_r.presc == ZERO_BYTE) && wdog_clear;
   endproperty
   a_wdog_clear_presc: assert property (p_wdog_clear_presc) else $error("watchdog clear left prescaler set"); // RULE17

   property p_rate;
      (q4 && !cs && !on_wdog && !sleep && (s_r.inhibit == 2'h0) && !wr &&
         ((s_r.presc & rate_mask(ps, 1'b0)) != rate_mask(ps, 1'b0))) |=>
         (s_r.timer_count == $past(s_r.timer_count));
   endproperty
   a_rate: assert property (p_rate) else $error("timer advanced before prescale ratio"); // RULE6

   property p_wdog_pass;
      (wdog_base_tick && !on_wdog) |=> wdog_timeout;
   endproperty
   a_wdog_pass: assert property (p_wdog_pass) else $error("watchdog tick lost without postscaler"); // RULE5

   property p_edge_capture;
      edge_now |=> s_r.edge_pend;
   endproperty
   a_edge_capture: assert property (p_edge_capture) else $error("synchronised edge not captured"); // RULE15

   property p_irq_pass;
      (s_r.flag && s_r.irq_en) |=> s_r.irq;
   endproperty
   a_irq_pass: assert property (p_irq_pass) else $error("enabled overflow request not passed on"); // RULE9

   property p_flag_hold;
      (s_r.flag && !wr) |=> s_r.flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("overflow flag cleared by hardware"); // RULE10

   property p_count_hold;
      (!inc_now && !wr) |=> (s_r.timer_count == $past(s_r.timer_count));
   endproperty
   a_count_hold: assert property (p_count_hold) else $error("count moved without increment or write"); // RULE22
endmodule

// ===== tmc_ext_src.sv
// external clock source model driving the count pin
module tmc_ext_src (
   input wire logic clk,
   input wire logic rstn,
   input wire logic go,
   input wire logic [7:0] half,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   // one pulse per go, high then low for half clocks each; idles low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 0;
         pin <= 1'b0;
      end else if (go) begin
         cnt <= 2 * int'(half);
         pin <= 1'b1;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         pin <= (cnt > int'(half) + 1);
      end
   end
endmodule

// ===== tb_tmc_timer.sv
// self-checking bench for the timer/counter block
module tb_tmc_timer
   import tmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, slp = 1'b0, clr = 1'b0, tick = 1'b0, go = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, half = 8'h28, rdata;
   logic pin, wclr, wto, irq;
   int n_mismatch = 0, total_checks = 0, cyc = 0, n_to = 0;
   always #50 clk = ~clk;
   always @(posedge clk) cyc <= cyc + int'(rstn);
   always @(posedge clk) n_to <= n_to + int'(wto);
   tmc_timer i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .sleep(slp), .external_count_input(pin), .watchdog_clear_instr(clr), .wdog_base_tick(tick),
      .wdog_clear(wclr), .wdog_timeout(wto), .overflow_irq(irq));
   tmc_ext_src i_src (.clk(clk), .rstn(rstn), .go(go), .half(half), .pin(pin));
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("mismatches %0d checks %0d", n_mismatch, total_checks);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // strobes launched on phase 0 so every access lands on phase 1
   task automatic align();
      @(posedge clk);
      while (cyc % 4 != 0) @(posedge clk);
   endtask
   task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
      align();
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rreg(input logic [7:0] ad, output logic [7:0] d);
      align();
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
      logic [7:0] d;
      rreg(ad, d);
      chk("register read", d, exp);
   endtask
   task automatic pulse_clr();
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      #1;
      chk("wdt_clear", wclr, 8'h01);
   endtask
   task automatic ticks(input int k);
      repeat (k) begin
         @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
      end
      idle(2);
   endtask
   task automatic t_reset();
      rchk(OFF_OPTION, OPTION_RST);
      rchk(OFF_TIMER, TIMER_RST);
      rchk(OFF_INTCTL, ZERO_BYTE);
      rchk(OFF_INTCTL_HI, ZERO_BYTE);
      rchk(8'h02, ZERO_BYTE);
   endtask
   task automatic t_timer();
      wreg(OFF_OPTION, 8'h08);
      wreg(OFF_TIMER, 8'h10);
      idle(76);
      rchk(OFF_TIMER, 8'h22);
      idle(36);
      rchk(OFF_TIMER, 8'h2c);
   endtask
   task automatic t_sleep();
      logic [7:0] a;
      @(posedge clk);
      slp <= 1'b1;
      rreg(OFF_TIMER, a);
      idle(36);
      rchk(OFF_TIMER, a);
      @(posedge clk);
      slp <= 1'b0;
   endtask
   task automatic t_ovf();
      wreg(OFF_TIMER, 8'hfd);
      idle(36);
      rchk(OFF_TIMER, 8'h05);
      rchk(OFF_INTCTL, 8'h04);
      chk("overflow_irq", irq, 8'h00);
      wreg(OFF_INTCTL, 8'h24);
      idle(1);
      chk("overflow_irq", irq, 8'h01);
      wreg(OFF_INTCTL, 8'h00);
      idle(1);
      chk("overflow_irq", irq, 8'h00);
      rchk(OFF_INTCTL_HI, ZERO_BYTE);
   endtask
   task automatic t_pre();
      logic [7:0] a;
      for (int n = 0; n < 8; n++) begin
         wreg(OFF_OPTION, 8'(n));
         rreg(OFF_TIMER, a);
         idle((16 << n) - 4);
         rchk(OFF_TIMER, a + 8'h02);
      end
   endtask
   task automatic t_wdt();
      int b;
      b = n_to;
      ticks(1);
      chk("timeouts", 8'(n_to), 8'(b + 1));
      wreg(OFF_TIMER, ZERO_BYTE);
      pulse_clr();
      wreg(OFF_OPTION, 8'h0a);
      pulse_clr();
      b = n_to;
      ticks(2);
      pulse_clr();
      ticks(3);
      chk("timeouts", 8'(n_to), 8'(b));
      ticks(1);
      chk("timeouts", 8'(n_to), 8'(b + 1));
   endtask
   task automatic t_edge();
      logic [7:0] a;
      for (int e = 0; e < 2; e++) begin
         wreg(OFF_OPTION, e ? 8'h38 : 8'h28);
         idle(20);
         rreg(OFF_TIMER, a);
         @(posedge clk);
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         idle(26);
         rchk(OFF_TIMER, e ? a : a + 8'h01);
         idle(60);
         rchk(OFF_TIMER, a + 8'h01);
      end
   endtask
   // counter mode through the prescaler at 1:2; timer write must clear the odd prescaler
   task automatic t_cnt_pre();
      ticks(1);
      wreg(OFF_OPTION, 8'h20);
      wreg(OFF_TIMER, ZERO_BYTE);
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         idle(90);
         rchk(OFF_TIMER, 8'(k));
      end
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_timer();
      t_sleep();
      t_ovf();
      t_pre();
      t_wdt();
      t_edge();
      t_cnt_pre();
      give_verdict();
   end
   initial begin
      #3000000;
      n_mismatch++;
      give_verdict();
   end
endmodule
